// ==== shared/asc_pkg.sv ====
// package for the asynchronous static memory host controller
package asc_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int CLK_PERIOD_NS = 40;

  // minimum device timings in ns
  localparam int T_RC_NS = 70;
  localparam int T_ACC_NS = 70;
  localparam int T_OE_NS = 35;
  localparam int T_WC_NS = 70;
  localparam int T_CW_NS = 60;
  localparam int T_AW_NS = 60;
  localparam int T_WP_NS = 50;
  localparam int T_DW_NS = 30;
  localparam int T_HZ_NS = 25;
  localparam int T_OW_NS = 5;

  // least times round up to whole cycles, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] RD_CYC = CNT_W'(cyc_up(T_ACC_NS > T_RC_NS ? T_ACC_NS : T_RC_NS));
  localparam logic [CNT_W-1:0] WR_CYC = CNT_W'(cyc_up(T_AW_NS > T_WP_NS ? T_AW_NS : T_WP_NS));
  localparam logic [CNT_W-1:0] TURN_CYC = CNT_W'(cyc_up(T_HZ_NS > T_OW_NS ? T_HZ_NS : T_OW_NS));
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  // request from the user side
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lane_en;
  } asc_req_t;

  // pin group toward the memory
  typedef struct packed {
    logic select_n;
    logic select_p;
    logic out_en_n;
    logic write_n;
    logic lower_lane_n;
    logic upper_lane_n;
    logic [ADDR_W-1:0] word_addr;
  } asc_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_WRITE = 3'b010,
    ST_WEND = 3'b011,
    ST_TURN = 3'b100
  } asc_state_t;
endpackage : asc_pkg

// ==== hdl/asc_sync.sv ====
// two-flop synchroniser for the data lines read back from the memory
`timescale 1ns/1ns
`default_nettype none
module asc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // data
  input wire logic [asc_pkg::DATA_W-1:0] din,
  output logic [asc_pkg::DATA_W-1:0] dout
);
  import asc_pkg::*;
  logic [DATA_W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule : asc_sync
`default_nettype wire

// ==== hdl/asc_host.sv ====
// host controller driving an asynchronous 512k x 16 static memory
// Behaviour
// - read: selected, write strobe high, output enable low
// - write: selected, write strobe low, some lane enabled
// - selects asserted at least 60 ns before write ends
// - address and lane enables held 60 ns before write ends
// - address stable no later than write start
// - write data valid 30 ns before write ends, held 0 ns after
// - write ends at first control deassertion; address may change then
// - read address valid before select and lanes become active; here it latches at the same edge as them
`timescale 1ns/1ns
`default_nettype none
module asc_host (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // user request side
  input wire logic req_valid,
  input wire asc_pkg::asc_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [asc_pkg::DATA_W-1:0] rsp_rdata,
  // memory pins
  output asc_pkg::asc_pins_t pins,
  input wire logic [asc_pkg::DATA_W-1:0] data_lines_in,
  output logic [asc_pkg::DATA_W-1:0] data_lines_out,
  output logic [asc_pkg::DATA_W-1:0] data_lines_oe
);
  import asc_pkg::*;

  // the input synchroniser adds two clocks before read data can be trusted
  localparam logic [CNT_W-1:0] SYNC_CYC = 4'h2;

  asc_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [DATA_W-1:0] rd_sync;
  logic [1:0] lanes_r;
  logic [1:0] req_lanes;
  logic take;
  logic take_rd;
  logic take_wr;
  logic cnt_last;
  logic rd_hold;
  logic wr_hold;

  // no request with both lanes off reaches the pins: it would be a deselect
  function automatic logic [1:0] lanes_of(input logic [1:0] en);
    return (en == 2'b00) ? 2'b11 : en;
  endfunction : lanes_of

  // spread one enable bit per lane over that lane's data bits
  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] en);
    return {{LANE_W{en[1]}}, {LANE_W{en[0]}}};
  endfunction : lane_mask

  // decodes shared by the strobe, drive and response logic
  assign req_lanes = lanes_of(req.lane_en);
  assign take = (state_r == ST_IDLE) && req_valid;
  assign take_rd = take && !req.write;
  assign take_wr = take && req.write;
  assign cnt_last = (cnt_r == CNT_ONE);
  // a read keeps its output enable, a write all its strobes, up to but not past its last counted clock
  assign rd_hold = (state_r == ST_READ) && !cnt_last;
  assign wr_hold = (state_r == ST_WRITE) && !cnt_last;

  asc_sync u_sync (
    .clk(clk),
    .reset(reset),
    .din(data_lines_in),
    .dout(rd_sync)
  );

  // sequencing: every phase lasts whole clocks covering its minimum
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      cnt_r <= CNT_ZERO;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (req_valid) begin
            state_r <= req.write ? ST_WRITE : ST_READ;
            // two extra clocks for the input synchroniser on reads
            cnt_r <= req.write ? WR_CYC : CNT_W'(RD_CYC + SYNC_CYC);
          end
        end
        ST_READ: begin
          if (cnt_r == CNT_ONE) begin
            state_r <= ST_TURN;
            cnt_r <= TURN_CYC;
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        ST_WRITE: begin
          if (cnt_r == CNT_ONE) begin
            state_r <= ST_WEND;
            cnt_r <= CNT_ONE;
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        ST_WEND: begin
          state_r <= ST_TURN;
          cnt_r <= TURN_CYC;
        end
        ST_TURN: begin
          // recovery lets memory drivers float before the next access
          if (cnt_r == CNT_ONE) begin
            state_r <= ST_IDLE;
            cnt_r <= CNT_ZERO;
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          cnt_r <= CNT_ZERO;
        end
      endcase
    end
  end

  // lanes and write data latch at acceptance; the address latches with the strobes
  always_ff @(posedge clk) begin
    if (reset) begin
      lanes_r <= 2'h0;
      data_lines_out <= '0;
    end else if (take) begin
      lanes_r <= req_lanes;
      data_lines_out <= req.wdata;
    end
  end

  // strobes: selected during the whole access, deselected with the write strobe or one cycle after output enable
  always_ff @(posedge clk) begin
    if (reset) begin
      pins.select_n <= 1'b1;
      pins.select_p <= 1'b0;
      pins.out_en_n <= 1'b1;
      pins.write_n <= 1'b1;
      pins.lower_lane_n <= 1'b1;
      pins.upper_lane_n <= 1'b1;
      pins.word_addr <= '0;
    end else begin
      // address latches at acceptance, at the same edge as the strobes first move
      if (take) begin
        pins.word_addr <= req.addr;
      end
      pins.select_n <= !(take || state_r == ST_READ || wr_hold);
      pins.select_p <= take || state_r == ST_READ || wr_hold;
      // read enables output; write keeps it high so it never fights the drivers
      pins.out_en_n <= !(take_rd || rd_hold);
      // write strobe and lanes held together so all three end at the same edge
      pins.write_n <= !(take_wr || wr_hold);
      if (take) begin
        pins.lower_lane_n <= !req_lanes[0];
        pins.upper_lane_n <= !req_lanes[1];
      end else if (state_r == ST_READ || wr_hold) begin
        pins.lower_lane_n <= !lanes_r[0];
        pins.upper_lane_n <= !lanes_r[1];
      end else begin
        pins.lower_lane_n <= 1'b1;
        pins.upper_lane_n <= 1'b1;
      end
    end
  end

  // host drives data only across the write plus one hold cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      data_lines_oe <= '0;
    end else if (take_wr) begin
      // drive stops one clock after the strobes, covering the zero data hold
      data_lines_oe <= lane_mask(req_lanes);
    end else if (state_r == ST_WRITE) begin
      data_lines_oe <= lane_mask(lanes_r);
    end else begin
      data_lines_oe <= '0;
    end
  end

  // read data sampled only once the access time plus sync delay elapsed
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= (state_r == ST_READ) && cnt_last;
      if ((state_r == ST_READ) && cnt_last) begin
        // disabled lanes read as zero since they float
        rsp_rdata <= rd_sync & lane_mask(lanes_r);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      req_ready <= 1'b0;
    end else begin
      // ready once the turnaround ends or while idle with no request, so a new take never meets live drivers
      req_ready <= (state_r == ST_TURN && cnt_r == CNT_ONE) ||
                   (state_r == ST_IDLE && !req_valid);
    end
  end
endmodule : asc_host
`default_nettype wire

// ==== tb/asc_mem_model.sv ====
// behavioural model of the 512k x 16 static memory
`timescale 1ns/1ns
`default_nettype none
module asc_mem_model (
  // memory pins
  input wire asc_pkg::asc_pins_t pins,
  input wire logic [asc_pkg::DATA_W-1:0] bus,
  output logic [asc_pkg::DATA_W-1:0] drv
);
  import asc_pkg::*;
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] m, wd, wm = '0, junk = 16'h3C5A;
  logic [ADDR_W-1:0] wa = '0;
  logic sel, wr;
  wire en_d;
  assign sel = !pins.select_n && pins.select_p;
  assign m = {{LANE_W{!pins.upper_lane_n}}, {LANE_W{!pins.lower_lane_n}}};
  assign wr = sel && !pins.write_n && m != 0;
  // slow to drive, quicker to let go
  assign #(70, 25) en_d = sel && pins.write_n && !pins.out_en_n;
  // released lines wander instead of keeping their last level
  always #40 junk = {junk[14:0], junk[15] ^ junk[12]};
  // words never written read back as zero
  function automatic logic [DATA_W-1:0] rd_word(input logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : '0;
  endfunction : rd_word
  always @* drv = en_d ? (rd_word(pins.word_addr) & m) | (junk & ~m) : junk;
  always @* if (wr) begin
    wa = pins.word_addr;
    wd = bus;
    wm = m;
  end
  always @(negedge wr) mem[wa] = (rd_word(wa) & ~wm) | (wd & wm);
endmodule : asc_mem_model
`default_nettype wire

// ==== tb/asc_host_sva.sv ====
// pin timing assertions for the host controller
`timescale 1ns/1ns
`default_nettype none
module asc_host_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // watched ports
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire asc_pkg::asc_pins_t pins,
  input wire logic [asc_pkg::DATA_W-1:0] data_lines_out,
  input wire logic [asc_pkg::DATA_W-1:0] data_lines_oe
);
  import asc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence wr_pulse; !pins.write_n ##1 pins.write_n; endsequence
  sequence rd_hold; (!pins.out_en_n)[*4] ##1 (pins.out_en_n && rsp_valid); endsequence
  AST_WR_QUAL: assert property (!pins.write_n |-> !pins.select_n && pins.select_p && pins.out_en_n
    && !(pins.lower_lane_n && pins.upper_lane_n)) else $error("write without select");
  AST_WR_LEN: assert property ($fell(pins.write_n) |-> ##1 wr_pulse) else $error("write pulse");
  AST_WR_HOLD: assert property (!pins.write_n && !$past(pins.write_n)
    |-> $stable(pins.word_addr) && $stable(data_lines_out)) else $error("write moved");
  AST_WR_END: assert property ($rose(pins.write_n) |-> pins.select_n && pins.lower_lane_n
    && pins.upper_lane_n && data_lines_oe != 0 ##1 data_lines_oe == 0) else $error("write end");
  AST_RD_LEN: assert property ($fell(pins.out_en_n) |-> rd_hold) else $error("read timing");
  AST_RD_QUAL: assert property (!pins.out_en_n |-> !pins.select_n && pins.write_n
    && data_lines_oe == 0) else $error("read qualifiers");
  AST_TURN: assert property ($rose(pins.out_en_n) |=> pins.out_en_n
    && data_lines_oe == 0) else $error("no turnaround");
  AST_IDLE: assert property (req_ready |-> pins.select_n && !pins.select_p && pins.write_n
    && pins.out_en_n && data_lines_oe == 0) else $error("idle pins");
  AST_RSP_ONE: assert property (rsp_valid |=> !rsp_valid) else $error("long response");
endmodule : asc_host_sva
bind asc_host asc_host_sva asc_host_sva_inst (.clk(clk), .reset(reset), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .pins(pins), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));
`default_nettype wire

// ==== tb/asc_host_tb.sv ====
// self-checking bench for the static memory host controller
`timescale 1ns/1ns
`default_nettype none
module asc_host_tb;
  import asc_pkg::*;
  logic clk = 0, reset = 1, req_valid = 0, req_ready, rsp_valid;
  asc_req_t req = '0;
  asc_pins_t pins;
  logic [DATA_W-1:0] rsp_rdata, dout, doe, drv, bus;
  logic [DATA_W-1:0] sh [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] q [$];
  logic [31:0] s = 32'h30;
  int err_total = 0, n_compared = 0;
  always #20 clk = ~clk;
  assign bus = (dout & doe) | (drv & ~doe);
  asc_host asc_host_inst (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins), .data_lines_in(bus), .data_lines_out(dout),
    .data_lines_oe(doe));
  asc_mem_model asc_mem_model_inst (.pins(pins), .bus(bus), .drv(drv));
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp, input string nm);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  function automatic logic [DATA_W-1:0] lm(input logic [1:0] l);
    if (l == 2'h0) l = 2'h3;
    return {{LANE_W{l[1]}}, {LANE_W{l[0]}}};
  endfunction : lm
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  // one request; reads note the expected word, unwritten lanes read as zero
  task automatic go(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] l);
    logic [DATA_W-1:0] old;
    for (int k = 0; k < 50 && req_ready !== 1'b1; k++) @(negedge clk);
    old = sh.exists(a) ? sh[a] : 16'h0;
    if (w) sh[a] = (old & ~lm(l)) | (d & lm(l));
    else q.push_back(old & lm(l));
    req_valid = 1'b1;
    req = {w, a, d, l};
    @(negedge clk);
    req_valid = 1'b0;
  endtask : go
  task automatic drain();
    for (int k = 0; k < 50 && q.size() > 0; k++) @(negedge clk);
    chk(16'(q.size()), 16'h0, "pending reads");
  endtask : drain
  task automatic rst();
    reset = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    chk({10'h0, pins.select_n, pins.select_p, pins.out_en_n, pins.write_n, pins.lower_lane_n,
      pins.upper_lane_n}, 16'h2F, "idle pins");
    chk(doe, 16'h0, "drive enable");
  endtask : rst
  always @(negedge clk) if (rsp_valid === 1'b1) begin
    if (q.size() == 0) chk(16'h1, 16'h0, "spare response");
    else chk(rsp_rdata, q.pop_front(), "read data");
  end
  initial begin
    rst();
    go(1'b1, 19'h0, 16'h1234, 2'h3);
    go(1'b1, 19'h7FFFF, 16'hBEEF, 2'h0);
    go(1'b0, 19'h0, 16'h0, 2'h3);
    go(1'b0, 19'h7FFFF, 16'h0, 2'h0);
    for (int i = 0; i < 8; i++) begin
      s = xs(s);
      go(1'b1, s[18:0], s[31:16], i[1:0]);
      go(1'b0, s[18:0], 16'h0, i[2:1]);
    end
    drain();
    rst();
    go(1'b0, 19'h7FFFF, 16'h0, 2'h3);
    drain();
    end_sim();
  end
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule : asc_host_tb
`default_nettype wire
